// ===== core/bstc_defines.vh
// Operation
// - held step-up past debounce raises tap one
// - held step-down past debounce lowers tap one
// - step inputs active low, idle high
// - tap held in 5-bit up/down counter
// - counter decoded one-hot to 32 taps
// - pulses shorter than 40 ms ignored
// - short push one step, long push repeats
// - slow repeat first second, then fast
// - slow step interval 250 ms typical
// - release stops stepping, resets scan timing
// - counter saturates at both ends
// - store-mode input debounced, low means auto-save unless locked
// - auto-save writes counter at power-down
// - power-up loads stored value before stepping
// - manual save on debounced store-mode rise
// - each valid store push saves once
// - store-mode low after high power-up locks steps
`ifndef BSTC_DEFINES_VH
`define BSTC_DEFINES_VH
`define BSTC_CLK_HZ 25000000
`define BSTC_DEBOUNCE_MS 40
`define BSTC_DEBOUNCE_CYC ((`BSTC_CLK_HZ / 1000) * `BSTC_DEBOUNCE_MS)
`define BSTC_SLOW_MS 250
`define BSTC_SLOW_CYC ((`BSTC_CLK_HZ / 1000) * `BSTC_SLOW_MS)
`define BSTC_FAST_MS 50
`define BSTC_FAST_CYC ((`BSTC_CLK_HZ / 1000) * `BSTC_FAST_MS)
`define BSTC_SCAN_MS 1000
`define BSTC_SCAN_CYC ((`BSTC_CLK_HZ / 1000) * `BSTC_SCAN_MS)
`define BSTC_TAP_W 5
`define BSTC_TAP_N 32
`define BSTC_TAP_MAX 5'h1F
`define BSTC_TAP_MIN 5'h00
`endif

// ===== core/bstc_debounce.v
`timescale 1ns/1ps
`include "bstc_defines.vh"
module bstc_debounce #(
  parameter [31:0] DEBOUNCE_CYC = `BSTC_DEBOUNCE_CYC
) (
  input wire clk,
  input wire rstn,
  input wire pin_n,
  output reg level_n
);
  reg sync1_reg;
  reg sync2_reg;
  reg [31:0] cnt_reg;
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      cnt_reg <= 32'h0000_0000;
      level_n <= 1'b1;
    end
    else
    begin
      sync1_reg <= pin_n;
      sync2_reg <= sync1_reg;
      // any bounce restarts the interval, so short pulses never pass
      if (sync2_reg == level_n)
        cnt_reg <= 32'h0000_0000;
      else if (cnt_reg >= DEBOUNCE_CYC - 32'h0000_0001)
      begin
        cnt_reg <= 32'h0000_0000;
        level_n <= sync2_reg;
      end
      else
        cnt_reg <= cnt_reg + 32'h0000_0001;
    end
  end
endmodule // bstc_debounce

// ===== core/bstc_tap_counter.v
`timescale 1ns/1ps
`include "bstc_defines.vh"
module bstc_tap_counter #(
  parameter [31:0] DEBOUNCE_CYC = `BSTC_DEBOUNCE_CYC,
  parameter [31:0] SLOW_CYC = `BSTC_SLOW_CYC,
  parameter [31:0] FAST_CYC = `BSTC_FAST_CYC,
  parameter [31:0] SCAN_CYC = `BSTC_SCAN_CYC
) (
  input wire clk,
  input wire rstn,
  input wire step_up_button_n,
  input wire step_down_button_n,
  input wire store_mode_select_n,
  input wire power_fail,
  input wire [4:0] nv_read_data,
  output reg [4:0] tap_position,
  output reg [31:0] tap_select,
  output reg nv_write,
  output reg [4:0] nv_write_data,
  output reg power_loss_save,
  output reg ready
);
  localparam [1:0] ST_LOAD = 2'd0;
  localparam [1:0] ST_IDLE = 2'd1;
  localparam [1:0] ST_SCAN = 2'd2;
  localparam [1:0] ST_OFF = 2'd3;

  wire up_n;
  wire dn_n;
  wire sel_n;
  reg [1:0] state_reg;
  reg [31:0] rate_reg;
  reg [31:0] held_reg;
  reg dir_up_reg;
  reg sel_prev_reg;
  reg lock_reg;
  reg strap_high_reg;
  reg pf_sync1_reg;
  reg pf_sync2_reg;
  reg step;
  reg [31:0] period;

  function [4:0] tap_move;
    input [4:0] pos;
    input up;
    begin
      if (up)
        tap_move = (pos == `BSTC_TAP_MAX) ? pos : pos + 5'h01;
      else
        tap_move = (pos == `BSTC_TAP_MIN) ? pos : pos - 5'h01;
    end
  endfunction

  function [31:0] one_hot;
    input [4:0] pos;
    begin
      one_hot = 32'h0000_0001 << pos;
    end
  endfunction

  bstc_debounce #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_db_up (
    .clk(clk),
    .rstn(rstn),
    .pin_n(step_up_button_n),
    .level_n(up_n)
  );
  bstc_debounce #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_db_dn (
    .clk(clk),
    .rstn(rstn),
    .pin_n(step_down_button_n),
    .level_n(dn_n)
  );
  bstc_debounce #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_db_sel (
    .clk(clk),
    .rstn(rstn),
    .pin_n(store_mode_select_n),
    .level_n(sel_n)
  );

  // repeat period: slow for the first second, then fast
  always @*
  begin
    if (held_reg >= SCAN_CYC)
      period = FAST_CYC;
    else
      period = SLOW_CYC;
  end

  always @*
  begin
    step = 1'b0;
    if (state_reg == ST_SCAN && !lock_reg && (up_n ^ dn_n))
      step = (rate_reg >= period - 32'h0000_0001);
  end

  always @(posedge clk)
  begin
    if (!rstn)
    begin
      state_reg <= ST_LOAD;
      rate_reg <= 32'h0000_0000;
      held_reg <= 32'h0000_0000;
      dir_up_reg <= 1'b0;
      sel_prev_reg <= 1'b1;
      lock_reg <= 1'b0;
      strap_high_reg <= 1'b1;
      pf_sync1_reg <= 1'b0;
      pf_sync2_reg <= 1'b0;
      tap_position <= `BSTC_TAP_MIN;
      tap_select <= 32'h0000_0001;
      nv_write <= 1'b0;
      nv_write_data <= `BSTC_TAP_MIN;
      power_loss_save <= 1'b0;
      ready <= 1'b0;
    end
    else
    begin
      pf_sync1_reg <= power_fail;
      pf_sync2_reg <= pf_sync1_reg;
      nv_write <= 1'b0;
      power_loss_save <= 1'b0;
      sel_prev_reg <= sel_n;
      tap_select <= one_hot(tap_position);
      // lock only when the strap read high at power-up and is pulled low later
      if (ready && sel_prev_reg && !sel_n && strap_high_reg)
        lock_reg <= 1'b1;
      if (ready && !sel_prev_reg && sel_n)
      begin
        lock_reg <= 1'b0;
        nv_write <= 1'b1;
        nv_write_data <= tap_position;
      end
      case (state_reg)
        ST_LOAD:
        begin
          tap_position <= nv_read_data;
          // two cycles past debounce so the strap level has settled
          // a strap still bouncing at power-up is read at its last debounced level
          if (held_reg >= DEBOUNCE_CYC + 32'h0000_0002)
          begin
            ready <= 1'b1;
            strap_high_reg <= sel_n;
            held_reg <= 32'h0000_0000;
            state_reg <= ST_IDLE;
          end
          else
            held_reg <= held_reg + 32'h0000_0001;
        end
        ST_IDLE:
        begin
          rate_reg <= 32'h0000_0000;
          held_reg <= 32'h0000_0000;
          if (pf_sync2_reg)
          begin
            if (!sel_n && !lock_reg)
            begin
              power_loss_save <= 1'b1;
              nv_write <= 1'b1;
              nv_write_data <= tap_position;
            end
            state_reg <= ST_OFF;
          end
          else if (!lock_reg && (up_n ^ dn_n))
          begin
            tap_position <= tap_move(tap_position, !up_n);
            dir_up_reg <= !up_n;
            state_reg <= ST_SCAN;
          end
        end
        ST_SCAN:
        begin
          if ((dir_up_reg ? up_n : dn_n) || pf_sync2_reg)
          begin
            state_reg <= ST_IDLE;
            rate_reg <= 32'h0000_0000;
            held_reg <= 32'h0000_0000;
          end
          else
          begin
            if (held_reg < SCAN_CYC)
              held_reg <= held_reg + 32'h0000_0001;
            if (step)
            begin
              rate_reg <= 32'h0000_0000;
              tap_position <= tap_move(tap_position, dir_up_reg);
            end
            else if (rate_reg < period)
              rate_reg <= rate_reg + 32'h0000_0001;
          end
        end
        ST_OFF:
        begin
          // stays off until power is fully restored and reset reapplied
          state_reg <= ST_OFF;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule // bstc_tap_counter

// ===== verification/bstc_tap_counter_props.sv
`timescale 1ns/1ps
module bstc_props (
  input wire clk,
  input wire rstn,
  input wire [4:0] nv_read_data,
  input wire [4:0] tap_position,
  input wire [31:0] tap_select,
  input wire nv_write,
  input wire [4:0] nv_write_data,
  input wire power_loss_save,
  input wire ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_hot; $onehot(tap_select); endproperty
  a_hot: assert property (p_hot) else $error("select not one-hot");
  property p_dec; tap_select == 32'h0000_0001 << $past(tap_position); endproperty
  a_dec: assert property (p_dec) else $error("select mismatch");
  property p_one; ready |=> tap_position - $past(tap_position) inside {5'h00, 5'h01, 5'h1f};
  endproperty
  a_one: assert property (p_one) else $error("jump over one tap");
  property p_top; ready && tap_position == 5'h1f |=> tap_position != 5'h00; endproperty
  a_top: assert property (p_top) else $error("wrap at top");
  property p_bot; ready && tap_position == 5'h00 |=> tap_position != 5'h1f; endproperty
  a_bot: assert property (p_bot) else $error("wrap at bottom");
  property p_pls; power_loss_save |-> nv_write; endproperty
  a_pls: assert property (p_pls) else $error("auto save without write");
  property p_wdat; nv_write |-> nv_write_data == tap_position; endproperty
  a_wdat: assert property (p_wdat) else $error("saved value wrong");
  property p_pulse; nv_write |=> !nv_write; endproperty
  a_pulse: assert property (p_pulse) else $error("save repeated");
  property p_load; !ready |=> tap_position == $past(nv_read_data); endproperty
  a_load: assert property (p_load) else $error("load value wrong");
endmodule // bstc_props
bind bstc_tap_counter bstc_props u_props (.clk(clk), .rstn(rstn), .nv_read_data(nv_read_data),
  .tap_position(tap_position), .tap_select(tap_select), .nv_write(nv_write),
  .nv_write_data(nv_write_data), .power_loss_save(power_loss_save), .ready(ready));

// ===== verification/bstc_buttons.sv
`timescale 1ns/1ps
module bstc_buttons (
  input wire clk,
  input wire push_up,
  input wire push_down,
  input wire push_store,
  input wire nv_write,
  input wire [4:0] nv_write_data,
  output wire step_up_button_n,
  output wire step_down_button_n,
  output wire store_mode_select_n,
  output wire [4:0] nv_read_data
);
  // cell survives reset, like the real array
  reg [4:0] mem_reg = 5'h03;
  // released contact reads high through the pull-up
  assign step_up_button_n = !push_up;
  assign step_down_button_n = !push_down;
  assign store_mode_select_n = !push_store;
  assign nv_read_data = mem_reg;
  always @(posedge clk)
    if (nv_write)
      mem_reg <= nv_write_data;
endmodule // bstc_buttons

// ===== verification/bstc_tap_counter_tb.sv
`timescale 1ns/1ps
module bstc_tap_counter_tb;
  // spacing between push events, above the 50 us minimum at 40 ns
  localparam integer GAP_CYC = 1260;
  reg clk = 1'b0;
  reg rstn = 1'b0;
  reg press_up = 1'b0;
  reg press_down = 1'b0;
  reg press_store = 1'b0;
  reg power_fail = 1'b0;
  wire up_n, dn_n, st_n, nv_write, power_loss_save, ready;
  wire [4:0] nv_read_data, nv_write_data, tap_position;
  wire [31:0] tap_select;
  integer bad_count = 0;
  integer checks_done = 0;
  integer wr_cnt = 0;
  integer pls_cnt = 0;
  always #20 clk = ~clk;
  always @(posedge clk)
    if (nv_write === 1'b1)
      wr_cnt <= wr_cnt + 1;
  always @(posedge clk)
    if (power_loss_save === 1'b1)
      pls_cnt <= pls_cnt + 1;
  bstc_buttons i_btn (.clk(clk), .push_up(press_up), .push_down(press_down),
    .push_store(press_store),
    .nv_write(nv_write), .nv_write_data(nv_write_data), .step_up_button_n(up_n),
    .step_down_button_n(dn_n), .store_mode_select_n(st_n), .nv_read_data(nv_read_data));
  bstc_tap_counter #(.DEBOUNCE_CYC(32'h0000_0014), .SLOW_CYC(32'h0000_0032),
    .FAST_CYC(32'h0000_000a), .SCAN_CYC(32'h0000_00c8)) i_dut (.clk(clk), .rstn(rstn),
    .step_up_button_n(up_n), .step_down_button_n(dn_n), .store_mode_select_n(st_n),
    .power_fail(power_fail), .nv_read_data(nv_read_data), .tap_position(tap_position),
    .tap_select(tap_select), .nv_write(nv_write), .nv_write_data(nv_write_data),
    .power_loss_save(power_loss_save), .ready(ready));
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string what, input [31:0] exp, input [31:0] got);
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task do_reset;
    integer k;
    rstn <= 1'b0;
    cyc(16);
    rstn <= 1'b1;
    for (k = 0; k < 100 && ready !== 1'b1; k = k + 1)
      cyc(1);
    chk("ready", 1, ready);
    if (ready !== 1'b1)
      wrap_up;
  endtask
  // push, release, then a gap above the minimum spacing
  task t_press(input u, input d, input integer n, input [4:0] exp);
    press_up <= u;
    press_down <= d;
    cyc(n);
    press_up <= 1'b0;
    press_down <= 1'b0;
    cyc(GAP_CYC);
    chk("tap", exp, tap_position);
    chk("select", 32'h0000_0001 << exp, tap_select);
  endtask
  task gap(output integer n);
    reg [4:0] p;
    p = tap_position;
    for (n = 0; n < 1000 && tap_position === p; n = n + 1)
      cyc(1);
    if (tap_position === p)
    begin
      chk("moved", 1, 0);
      wrap_up;
    end
  endtask
  task t_hold;
    integer n;
    press_up <= 1'b1;
    gap(n);
    gap(n);
    chk("slow gap", 50, n);
    cyc(250);
    gap(n);
    gap(n);
    chk("fast gap", 10, n);
    cyc(300);
    chk("ceiling", 31, tap_position);
    press_up <= 1'b0;
    cyc(GAP_CYC);
  endtask
  task t_store;
    integer w;
    w = wr_cnt;
    press_store <= 1'b1;
    cyc(GAP_CYC);
    t_press(1, 0, 30, 5'h02);
    press_store <= 1'b0;
    cyc(GAP_CYC);
    chk("saves", w + 1, wr_cnt);
    chk("stored", 2, nv_read_data);
    t_press(1, 0, 30, 5'h03);
  endtask
  task t_auto;
    integer s;
    press_store <= 1'b1;
    do_reset;
    chk("restored", 2, tap_position);
    t_press(0, 1, 30, 5'h01);
    s = pls_cnt;
    power_fail <= 1'b1;
    cyc(10);
    chk("auto save", s + 1, pls_cnt);
    power_fail <= 1'b0;
    press_store <= 1'b0;
    do_reset;
    chk("recalled", 1, tap_position);
  endtask
  initial
  begin
    do_reset;
    chk("loaded", 3, tap_position);
    t_press(1, 0, 30, 5'h04);
    t_press(1, 0, 10, 5'h04);
    t_press(0, 1, 30, 5'h03);
    t_press(1, 1, 100, 5'h03);
    t_hold;
    t_press(0, 1, 600, 5'h00);
    t_press(1, 0, 80, 5'h02);
    t_store;
    t_auto;
    wrap_up;
  end
endmodule // bstc_tap_counter_tb
